// file: hw/icc_channel.sv
// icc_channel: one input capture channel with four-entry buffer and ahb-lite registers
// assumes ticks and source events come from logic on core_clk; the pin is asynchronous
`timescale 1ns/1ps
module icc_channel #(
  parameter bit IS_UPPER = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register bus
  input wire icc_pkg::icc_ahb_req_type ahbReq,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // capture pin and counter sources
  input wire logic capturePin,
  input wire icc_pkg::icc_ticks_type timerTick,
  input wire logic [31:0] sourceEvent,
  // cpu power state
  input wire logic cpuIdle,
  input wire logic cpuSleep,
  // cascade partner
  input wire logic partnerCascade,
  input wire logic partnerRollover,
  input wire logic partnerCapture,
  output logic cascadeSelect,
  output logic counterRollover,
  output logic captureStrobe,
  // events out
  output logic captureIrq,
  output logic wakeIrq
);

  typedef struct packed {
    logic [2:0] pinSync;
    logic pinLevel;
    logic idleStop;
    logic [2:0] clockSel;
    logic [1:0] perIrq;
    logic [2:0] mode;
    logic cascade;
    logic trigSel;
    logic trigStatus;
    logic [4:0] srcSel;
    logic srcDelay;
    logic [15:0] counter;
    logic [icc_pkg::FIFO_DEPTH-1:0][15:0] fifoMem;
    logic [1:0] wrPtr;
    logic [1:0] rdPtr;
    logic [2:0] fifoCount;
    logic overflow;
    logic [3:0] presc;
    logic [1:0] irqCount;
    logic irqPulse;
    logic wakePulse;
    logic rollPulse;
    logic capPulse;
    logic dataWrite;
    logic [7:0] dataAddr;
    logic [31:0] rdata;
  } icc_state_type;

  icc_state_type st_reg;
  icc_state_type st_next;

  // selected counter clock tick
  function automatic logic tickSelect(input logic [2:0] sel, input icc_pkg::icc_ticks_type t);
    case (sel)
      icc_pkg::TSEL_PERIPH: tickSelect = 1'b1;
      icc_pkg::TSEL_T1: tickSelect = t.timer1;
      icc_pkg::TSEL_T5: tickSelect = t.timer5;
      icc_pkg::TSEL_T4: tickSelect = t.timer4;
      icc_pkg::TSEL_T2: tickSelect = t.timer2;
      icc_pkg::TSEL_T3: tickSelect = t.timer3;
      default: tickSelect = 1'b0;
    endcase
  endfunction

  // register readback images
  function automatic logic [31:0] ctl1Image(input icc_state_type s);
    ctl1Image = '0;
    ctl1Image[icc_pkg::C1_IDLE] = s.idleStop;
    ctl1Image[icc_pkg::C1_TSEL +: 3] = s.clockSel;
    ctl1Image[icc_pkg::C1_ICI +: 2] = s.perIrq;
    ctl1Image[icc_pkg::C1_OV] = s.overflow;
    ctl1Image[icc_pkg::C1_BNE] = (s.fifoCount != 3'h0);
    ctl1Image[icc_pkg::C1_MODE +: 3] = s.mode;
  endfunction

  logic cascadeOn;
  logic running;
  logic tick;
  logic srcValid;
  logic srcHit;
  logic risePin;
  logic fallPin;
  logic localEvent;
  logic capEvent;
  logic addrPhase;
  logic popReq;
  logic pushOk;
  logic newLevel;

  always_comb begin
    st_next = st_reg;
    // three-stage pin synchroniser, level accepted when stages two and three agree
    st_next.pinSync = {st_reg.pinSync[1:0], capturePin};
    newLevel = (st_reg.pinSync[1] == st_reg.pinSync[2]) ? st_reg.pinSync[2] : st_reg.pinLevel;
    st_next.pinLevel = newLevel;
    risePin = newLevel & ~st_reg.pinLevel;
    fallPin = ~newLevel & st_reg.pinLevel;

    // pair acts as one only when both halves ask for it
    cascadeOn = st_reg.cascade & partnerCascade;
    running = (st_reg.mode >= icc_pkg::MODE_BOTH) && (st_reg.mode <= icc_pkg::MODE_DIV16)
      && !(st_reg.idleStop && cpuIdle);
    // upper half counts the lower half's rollovers
    tick = (cascadeOn && IS_UPPER) ? partnerRollover
      : tickSelect(st_reg.clockSel, timerTick);

    // source decode; capture counter sources are delayed a cycle past their rollover
    srcValid = icc_pkg::SRC_VALID_MAP[st_reg.srcSel];
    st_next.srcDelay = sourceEvent[st_reg.srcSel];
    if ((st_reg.srcSel >= icc_pkg::SRC_ICC_FIRST) && (st_reg.srcSel <= icc_pkg::SRC_ICC_LAST)) begin
      srcHit = srcValid & st_reg.srcDelay;
    end else begin
      srcHit = srcValid & sourceEvent[st_reg.srcSel];
    end

    // counter: trigger mode gates on status, sync mode clears on source
    st_next.rollPulse = 1'b0;
    if (st_reg.trigSel) begin
      if (srcHit) begin
        st_next.trigStatus = 1'b1;
      end
      if (!st_reg.trigStatus) begin
        st_next.counter = '0;
      end else if (running && tick) begin
        st_next.counter = st_reg.counter + 16'h0001;
        st_next.rollPulse = (st_reg.counter == icc_pkg::CNT_MAX);
      end
    end else if (srcHit) begin
      st_next.counter = '0;
    end else if (running && tick) begin
      st_next.counter = st_reg.counter + 16'h0001;
      st_next.rollPulse = (st_reg.counter == icc_pkg::CNT_MAX);
    end

    // edge selection per mode
    localEvent = 1'b0;
    case (st_reg.mode)
      icc_pkg::MODE_BOTH: localEvent = risePin | fallPin;
      icc_pkg::MODE_RISE: localEvent = risePin;
      icc_pkg::MODE_FALL: localEvent = fallPin;
      icc_pkg::MODE_DIV4, icc_pkg::MODE_DIV16: begin
        if (risePin) begin
          if (st_reg.presc == ((st_reg.mode == icc_pkg::MODE_DIV4)
              ? icc_pkg::PRESC_LAST4 : icc_pkg::PRESC_LAST16)) begin
            localEvent = 1'b1;
            st_next.presc = '0;
          end else begin
            st_next.presc = st_reg.presc + 4'h1;
          end
        end
      end
      default: localEvent = 1'b0;
    endcase
    // upper half captures on the lower half's event
    capEvent = running && ((cascadeOn && IS_UPPER) ? partnerCapture : localEvent);
    st_next.capPulse = capEvent;

    // wake pin: rising edge only, only while asleep or idle
    st_next.wakePulse = (st_reg.mode == icc_pkg::MODE_WAKE) && risePin
      && (cpuSleep || cpuIdle);

    // interrupt counting; field ignored in every-edge mode
    st_next.irqPulse = 1'b0;
    if (capEvent) begin
      // at-or-past compare so a lowered divider takes effect at once, not after a wrap
      if (st_reg.mode == icc_pkg::MODE_BOTH || st_reg.irqCount >= st_reg.perIrq) begin
        st_next.irqPulse = 1'b1;
        st_next.irqCount = '0;
      end else begin
        st_next.irqCount = st_reg.irqCount + 2'h1;
      end
    end

    // bus address phase; reads are answered from a register one cycle later
    addrPhase = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
    popReq = addrPhase && !ahbReq.hwrite && (ahbReq.haddr == icc_pkg::OFS_BUF)
      && (st_reg.fifoCount != 3'h0);
    st_next.dataWrite = addrPhase && ahbReq.hwrite;
    st_next.dataAddr = ahbReq.haddr;
    st_next.rdata = '0;
    if (addrPhase && !ahbReq.hwrite) begin
      case (ahbReq.haddr)
        icc_pkg::OFS_CTL1: st_next.rdata = ctl1Image(st_reg);
        icc_pkg::OFS_CTL2: begin
          st_next.rdata[icc_pkg::C2_CASC] = st_reg.cascade;
          st_next.rdata[icc_pkg::C2_TRIG] = st_reg.trigSel;
          st_next.rdata[icc_pkg::C2_TSTAT] = st_reg.trigStatus;
          st_next.rdata[icc_pkg::C2_SEL +: 5] = st_reg.srcSel;
        end
        icc_pkg::OFS_BUF: st_next.rdata[15:0] = st_reg.fifoMem[st_reg.rdPtr];
        icc_pkg::OFS_CNT: st_next.rdata[15:0] = st_reg.counter;
        default: st_next.rdata = '0;
      endcase
    end

    // buffer push and pop; a full buffer drops the new value
    pushOk = capEvent && (st_reg.fifoCount != icc_pkg::FIFO_FULL);
    if (pushOk) begin
      st_next.fifoMem[st_reg.wrPtr] = st_reg.counter;
      st_next.wrPtr = st_reg.wrPtr + 2'h1;
    end
    if (popReq) begin
      st_next.rdPtr = st_reg.rdPtr + 2'h1;
    end
    st_next.fifoCount = st_reg.fifoCount + {2'h0, pushOk} - {2'h0, popReq};
    // overflow clears on a read that frees room; a new overflow wins
    if (popReq) begin
      st_next.overflow = 1'b0;
    end
    if (capEvent && !pushOk) begin
      st_next.overflow = 1'b1;
    end

    // data phase writes
    if (st_reg.dataWrite) begin
      case (st_reg.dataAddr)
        icc_pkg::OFS_CTL1: begin
          st_next.idleStop = ahbReq.hwdata[icc_pkg::C1_IDLE];
          st_next.clockSel = ahbReq.hwdata[icc_pkg::C1_TSEL +: 3];
          st_next.perIrq = ahbReq.hwdata[icc_pkg::C1_ICI +: 2];
          st_next.mode = ahbReq.hwdata[icc_pkg::C1_MODE +: 3];
          if (ahbReq.hwdata[icc_pkg::C1_MODE +: 3] != st_reg.mode) begin
            st_next.presc = '0;
            st_next.irqCount = '0;
          end
          if (ahbReq.hwdata[icc_pkg::C1_MODE +: 3] == icc_pkg::MODE_OFF) begin
            st_next.fifoCount = '0;
            st_next.wrPtr = '0;
            st_next.rdPtr = '0;
            st_next.overflow = 1'b0;
          end
        end
        icc_pkg::OFS_CTL2: begin
          st_next.cascade = ahbReq.hwdata[icc_pkg::C2_CASC];
          st_next.trigSel = ahbReq.hwdata[icc_pkg::C2_TRIG];
          // the source setting the status wins over a software clear
          st_next.trigStatus = ahbReq.hwdata[icc_pkg::C2_TSTAT]
            | (st_reg.trigSel && srcHit);
          st_next.srcSel = ahbReq.hwdata[icc_pkg::C2_SEL +: 5];
        end
        icc_pkg::OFS_CNT: st_next.counter = ahbReq.hwdata[15:0];
        default: st_next.srcDelay = st_next.srcDelay;
      endcase
    end
  end

  // single state register; source defaults to timer 3
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.srcSel <= icc_pkg::SRC_TIMER3;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register; no wait states, always okay
  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cascadeSelect = st_reg.cascade;
  assign counterRollover = st_reg.rollPulse;
  assign captureStrobe = st_reg.capPulse;
  assign captureIrq = st_reg.irqPulse;
  assign wakeIrq = st_reg.wakePulse;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // buffer and flags; a pop or a control write in the same cycle would move the count
  a_full_sets_ov: assert property (capEvent && !popReq && !st_reg.dataWrite
    && st_reg.fifoCount == icc_pkg::FIFO_FULL
    |=> st_reg.overflow && st_reg.fifoCount == icc_pkg::FIFO_FULL)
    else $error("overflow not flagged on full buffer");
  a_push_grows: assert property (pushOk && !popReq && !st_reg.dataWrite
    |=> st_reg.fifoCount == $past(st_reg.fifoCount) + 3'h1)
    else $error("capture not stored");
  a_pop_shrinks: assert property (popReq && !pushOk && !st_reg.dataWrite
    |=> st_reg.fifoCount == $past(st_reg.fifoCount) - 3'h1)
    else $error("read did not free a slot");
  a_count_bound: assert property (st_reg.fifoCount <= icc_pkg::FIFO_FULL)
    else $error("buffer count beyond depth");
  a_ov_sticky: assert property (st_reg.overflow && !popReq && !st_reg.dataWrite
    |=> st_reg.overflow)
    else $error("overflow flag lost");
  a_bne_image: assert property (addrPhase && !ahbReq.hwrite
    && ahbReq.haddr == icc_pkg::OFS_CTL1
    |=> hrdata[icc_pkg::C1_BNE] == ($past(st_reg.fifoCount) != 3'h0))
    else $error("not-empty flag wrong");
  a_off_flush: assert property (st_reg.dataWrite && st_reg.dataAddr == icc_pkg::OFS_CTL1
    && ahbReq.hwdata[icc_pkg::C1_MODE +: 3] == icc_pkg::MODE_OFF
    |=> st_reg.fifoCount == 3'h0 && !st_reg.overflow)
    else $error("turning off kept buffered values");

  // counter, trigger and synchronisation
  a_held_clear: assert property (st_reg.trigSel && !st_reg.trigStatus
    && !st_reg.dataWrite |=> st_reg.counter == 16'h0000)
    else $error("counter runs before trigger");
  a_trig_sets: assert property (st_reg.trigSel && srcHit |=> st_reg.trigStatus)
    else $error("source did not set trigger status");
  a_sync_clears: assert property (!st_reg.trigSel && srcHit && !st_reg.dataWrite
    |=> st_reg.counter == 16'h0000)
    else $error("sync event did not clear counter");
  a_idle_halt: assert property (st_reg.idleStop && cpuIdle && !srcHit
    && !st_reg.dataWrite && !(st_reg.trigSel && !st_reg.trigStatus)
    |=> $stable(st_reg.counter))
    else $error("counter moved in idle");
  a_roll_cause: assert property (counterRollover
    |-> $past(st_reg.counter) == icc_pkg::CNT_MAX)
    else $error("rollover pulse without a wrap");

  // edges, interrupts and modes; a cascaded upper half follows its partner instead
  a_rise_match: assert property (capEvent && !(cascadeOn && IS_UPPER)
    && st_reg.mode == icc_pkg::MODE_RISE |-> risePin)
    else $error("rising capture without a rising edge");
  a_fall_match: assert property (capEvent && !(cascadeOn && IS_UPPER)
    && st_reg.mode == icc_pkg::MODE_FALL |-> fallPin)
    else $error("falling capture without a falling edge");
  a_div4_count: assert property (capEvent && !(cascadeOn && IS_UPPER)
    && st_reg.mode == icc_pkg::MODE_DIV4 |-> risePin && st_reg.presc == icc_pkg::PRESC_LAST4)
    else $error("prescaled capture off its count");
  a_irq_cause: assert property (captureIrq |-> $past(capEvent))
    else $error("interrupt without capture");
  a_single_irq: assert property (capEvent && st_reg.perIrq == 2'h0 |=> captureIrq)
    else $error("capture without interrupt at one per interrupt");
  a_every_edge_irq: assert property (capEvent && st_reg.mode == icc_pkg::MODE_BOTH
    |=> captureIrq)
    else $error("every-edge capture without interrupt");
  a_wake_only: assert property (wakeIrq
    |-> $past(st_reg.mode) == icc_pkg::MODE_WAKE && !captureStrobe)
    else $error("wake outside wake mode");
  a_wake_awake: assert property (!cpuSleep && !cpuIdle |=> !wakeIrq)
    else $error("wake pulse while cpu awake");
  a_off_quiet: assert property (st_reg.mode == icc_pkg::MODE_OFF |=> !captureStrobe)
    else $error("capture while off");

  c_overflow: cover property (capEvent && st_reg.fifoCount == icc_pkg::FIFO_FULL);
  c_fourth_irq: cover property (captureIrq && st_reg.perIrq == 2'h3);
  c_wake: cover property (wakeIrq);
  c_trigger_start: cover property (st_reg.trigSel && srcHit && !st_reg.trigStatus);
  c_rollover: cover property (counterRollover);
endmodule

// file: hw/icc_pkg.sv
// icc_pkg: constants and carrier types of the input capture channel
// assumes a single core_clk domain and an AHB-Lite register port
package icc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTL1 = 8'h00;
  localparam logic [7:0] OFS_CTL2 = 8'h04;
  localparam logic [7:0] OFS_BUF = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  // control one field positions
  localparam int C1_IDLE = 13;
  localparam int C1_TSEL = 10;
  localparam int C1_ICI = 5;
  localparam int C1_OV = 4;
  localparam int C1_BNE = 3;
  localparam int C1_MODE = 0;
  // control two field positions
  localparam int C2_CASC = 8;
  localparam int C2_TRIG = 7;
  localparam int C2_TSTAT = 6;
  localparam int C2_SEL = 0;
  // capture modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_BOTH = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_DIV4 = 3'h4;
  localparam logic [2:0] MODE_DIV16 = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h6;
  localparam logic [2:0] MODE_WAKE = 3'h7;
  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;
  // counter clock selections
  localparam logic [2:0] TSEL_T3 = 3'h0;
  localparam logic [2:0] TSEL_T2 = 3'h1;
  localparam logic [2:0] TSEL_T4 = 3'h2;
  localparam logic [2:0] TSEL_T5 = 3'h3;
  localparam logic [2:0] TSEL_T1 = 3'h4;
  localparam logic [2:0] TSEL_PERIPH = 3'h7;
  // trigger and sync source codes
  localparam logic [4:0] SRC_ICC_FIRST = 5'h05;
  localparam logic [4:0] SRC_ICC_LAST = 5'h08;
  localparam logic [4:0] SRC_TIMER3 = 5'h0d;
  localparam logic [31:0] SRC_VALID_MAP = 32'h1fcf_f9fe;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL = 3'h4;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // timer clock ticks, one cycle wide each
  typedef struct packed {
    logic timer5;
    logic timer4;
    logic timer3;
    logic timer2;
    logic timer1;
  } icc_ticks_type;
  // address and data of an ahb-lite request
  typedef struct packed {
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } icc_ahb_req_type;
endpackage

// file: verification/icc_channel_tb_top.sv
// icc_channel_tb_top: self-checking bench for one input capture channel
// assumes a lone lower channel; cascade partner strobes stay quiet except one pulse in t_trigger
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; \
  if ((a) !== (e)) begin failures++; $display("Error %0t: got %h expected %h", $time, a, e); end end
module icc_channel_tb_top;
  logic core_clk;
  logic reset_n;
  logic cpuIdle;
  logic cpuSleep;
  logic partnerCascade;
  icc_pkg::icc_ahb_req_type ahbReq;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic partnerRollover;
  logic partnerCapture;
  logic counterRollover;
  logic capturePin;
  icc_pkg::icc_ticks_type timerTick;
  logic [31:0] sourceEvent;
  logic captureStrobe;
  logic captureIrq;
  logic wakeIrq;
  logic cascadeSelect;
  logic [31:0] rd;
  logic [15:0] v [4];
  int failures;
  int comparisons;
  int nStrobe;
  int nIrq;
  int nWake;
  int nRoll;

  icc_channel i_icc_channel (.core_clk(core_clk), .reset_n(reset_n), .ahbReq(ahbReq),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capturePin(capturePin),
    .timerTick(timerTick), .sourceEvent(sourceEvent), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
    .partnerCascade(partnerCascade), .partnerRollover(partnerRollover),
    .partnerCapture(partnerCapture), .cascadeSelect(cascadeSelect),
    .counterRollover(counterRollover), .captureStrobe(captureStrobe),
    .captureIrq(captureIrq), .wakeIrq(wakeIrq));
  icc_pulse_source i_icc_pulse_source (.core_clk(core_clk), .capturePin(capturePin),
    .timerTick(timerTick), .sourceEvent(sourceEvent));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // pulse counters; single-cycle outputs are counted at every rising edge
  always @(posedge core_clk) begin
    nStrobe += int'(captureStrobe === 1'b1);
    nIrq += int'(captureIrq === 1'b1);
    nWake += int'(wakeIrq === 1'b1);
    nRoll += int'(counterRollover === 1'b1);
  end

  // one ahb-lite single word; waits on hready, read data taken at the data phase end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    ahbReq <= '{1'b1, a, 2'b10, wr, 3'b010, hreadyout, ahbReq.hwdata};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    ahbReq <= '{1'b0, a, 2'b00, wr, 3'b010, hreadyout, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic t_reset();
    bus(1'b0, icc_pkg::OFS_CTL1, 32'h0);
    `CHK(rd, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    bus(1'b0, icc_pkg::OFS_CTL2, 32'h0);
    `CHK(rd, 32'h0000_000d)
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_0000)
  endtask

  // every mode and interrupt divider, buffer drained after each pulse
  task automatic t_modes();
    logic [2:0] md [9] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7};
    int captures_per_irq [9] = '{3, 0, 3, 2, 1, 0, 0, 0, 0};
    int ns [9] = '{32, 16, 16, 16, 4, 1, 0, 0, 0};
    int ni [9] = '{32, 16, 4, 5, 2, 1, 0, 0, 0};
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, icc_pkg::OFS_CTL1, 32'h1c00 | (32'(captures_per_irq[i]) << 5) | 32'(md[i]));
      nStrobe = 0;
      nIrq = 0;
      repeat (16) begin
        i_icc_pulse_source.pulses(1);
        bus(1'b0, icc_pkg::OFS_BUF, 32'h0);
        bus(1'b0, icc_pkg::OFS_BUF, 32'h0);
      end
      repeat (8) @(posedge core_clk);
      `CHK(nStrobe, ns[i])
      `CHK(nIrq, ni[i])
    end
  endtask

  // five rises into four slots: first four kept in order, overflow shown
  task automatic t_overflow();
    bus(1'b1, icc_pkg::OFS_CTL1, 32'h0000_1c03);
    i_icc_pulse_source.pulses(5);
    repeat (6) @(posedge core_clk);
    bus(1'b0, icc_pkg::OFS_CTL1, 32'h0);
    `CHK(rd, 32'h0000_1c1b)
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, icc_pkg::OFS_BUF, 32'h0);
      v[k] = rd[15:0];
    end
    `CHK(16'(v[1] - v[0]), 16'h0010)
    `CHK(16'(v[3] - v[0]), 16'h0030)
    bus(1'b0, icc_pkg::OFS_CTL1, 32'h0);
    `CHK(rd, 32'h0000_1c03)
  endtask

  task automatic t_idle();
    bus(1'b1, icc_pkg::OFS_CTL1, 32'h0000_3c03);
    cpuIdle <= 1'b1;
    nStrobe = 0;
    i_icc_pulse_source.pulses(2);
    repeat (8) @(posedge core_clk);
    `CHK(nStrobe, 0)
    bus(1'b1, icc_pkg::OFS_CTL1, 32'h0000_1c03);
    nStrobe = 0;
    i_icc_pulse_source.pulses(2);
    repeat (8) @(posedge core_clk);
    `CHK(nStrobe, 2)
    cpuIdle <= 1'b0;
    bus(1'b1, icc_pkg::OFS_CTL1, 32'h0);
  endtask

  task automatic t_wake();
    bus(1'b1, icc_pkg::OFS_CTL1, 32'h0000_0007);
    cpuSleep <= 1'b1;
    nWake = 0;
    nStrobe = 0;
    i_icc_pulse_source.pulses(2);
    repeat (8) @(posedge core_clk);
    `CHK(nWake, 2)
    `CHK(nStrobe, 0)
    cpuSleep <= 1'b0;
    nWake = 0;
    i_icc_pulse_source.pulses(1);
    repeat (8) @(posedge core_clk);
    `CHK(nWake, 0)
  endtask

  // each timer clock select counts only its own timer's ticks
  task automatic t_clksel();
    int tb [5] = '{2, 1, 3, 4, 0};
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, icc_pkg::OFS_CTL1, (32'(c) << 10) | 32'h3);
      bus(1'b1, icc_pkg::OFS_CNT, 32'h0);
      i_icc_pulse_source.ticks(tb[c], 5);
      i_icc_pulse_source.ticks((tb[c] + 1) % 5, 3);
      repeat (4) @(posedge core_clk);
      bus(1'b0, icc_pkg::OFS_CNT, 32'h0);
      `CHK(rd, 32'h0000_0005)
    end
  endtask

  task automatic t_trigger();
    bus(1'b1, icc_pkg::OFS_CTL1, 32'h0000_1c03);
    bus(1'b1, icc_pkg::OFS_CTL2, 32'h0000_008d);
    bus(1'b1, icc_pkg::OFS_CNT, 32'h0000_0100);
    repeat (4) @(posedge core_clk);
    bus(1'b0, icc_pkg::OFS_CNT, 32'h0);
    `CHK(rd, 32'h0000_0000)
    i_icc_pulse_source.event_pulse(13);
    repeat (4) @(posedge core_clk);
    bus(1'b0, icc_pkg::OFS_CTL2, 32'h0);
    `CHK(rd, 32'h0000_00cd)
    bus(1'b0, icc_pkg::OFS_CNT, 32'h0);
    `CHK(rd[15:0] == 16'h0000, 1'b0)
    bus(1'b1, icc_pkg::OFS_CTL2, 32'h0000_0005);
    bus(1'b1, icc_pkg::OFS_CNT, 32'h0000_8000);
    i_icc_pulse_source.event_pulse(5);
    bus(1'b0, icc_pkg::OFS_CNT, 32'h0);
    `CHK(rd[15:0], 16'h0000)
    // one wrap from near the top gives exactly one rollover pulse
    nRoll = 0;
    bus(1'b1, icc_pkg::OFS_CNT, 32'h0000_fff0);
    repeat (20) @(posedge core_clk);
    `CHK(nRoll, 1)
    partnerCascade <= 1'b1;
    bus(1'b1, icc_pkg::OFS_CTL2, 32'h0000_010d);
    repeat (2) @(posedge core_clk);
    `CHK(cascadeSelect, 1'b1)
    // a lower half keeps to its own pin even with partner strobes present
    nStrobe = 0;
    partnerCapture <= 1'b1;
    partnerRollover <= 1'b1;
    @(posedge core_clk);
    partnerCapture <= 1'b0;
    partnerRollover <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(nStrobe, 0)
    bus(1'b1, icc_pkg::OFS_CTL2, 32'h0000_000d);
    partnerCascade <= 1'b0;
  endtask

  // reset, then the scenarios in turn
  initial begin
    reset_n = 1'b0;
    cpuIdle = 1'b0;
    cpuSleep = 1'b0;
    partnerCascade = 1'b0;
    partnerRollover = 1'b0;
    partnerCapture = 1'b0;
    ahbReq = '{1'b0, 8'h00, 2'b00, 1'b0, 3'b010, 1'b1, 32'h0};
    failures = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_modes();
    t_overflow();
    t_idle();
    t_wake();
    t_clksel();
    t_trigger();
    close_out();
  end
  // watchdog, well beyond the roughly 3800 cycles the scenarios need
  initial begin
    repeat (50000) @(posedge core_clk);
    failures++;
    close_out();
  end
endmodule

// file: verification/icc_pulse_source.sv
// icc_pulse_source: far-side model for the capture pin, timer ticks and trigger sources
// assumes the bench calls one task at a time, all on core_clk
`timescale 1ns/1ps
module icc_pulse_source (
  // clock
  input wire logic core_clk,
  // stimulus toward the channel
  output logic capturePin,
  output icc_pkg::icc_ticks_type timerTick,
  output logic [31:0] sourceEvent
);
  // idle levels; the pin rests low between pulses
  initial begin
    capturePin = 1'b0;
    timerTick = '0;
    sourceEvent = '0;
  end
  // whole pulses of 16 cycles, each level long enough for the three-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk) capturePin <= 1'b1;
      repeat (8) @(posedge core_clk);
      capturePin <= 1'b0;
      repeat (7) @(posedge core_clk);
    end
  endtask
  // one-cycle ticks on a single timer line
  task automatic ticks(input int b, input int n);
    repeat (n) begin
      @(posedge core_clk) timerTick <= icc_pkg::icc_ticks_type'(5'h01 << b);
      @(posedge core_clk) timerTick <= '0;
    end
  endtask
  // one-cycle source event; never the channel's own code, default source stays timer 3
  task automatic event_pulse(input int code);
    @(posedge core_clk) sourceEvent <= 32'h0000_0001 << code;
    @(posedge core_clk) sourceEvent <= '0;
  endtask
endmodule
